// file: verilog/external_pin_interrupt_ctrl.sv
`timescale 1ns/100ps
`default_nettype none

module external_pin_interrupt_ctrl #(
    parameter int LOW_PINS  = 8,
    parameter int HIGH_PINS = 4
) (
    // Clock and reset
    input  wire logic                  i_clk,
    input  wire logic                  i_rst,
    // Register port
    input  wire logic [7:0]            i_addr,
    input  wire logic [7:0]            i_wdata,
    input  wire logic                  i_wr,
    input  wire logic                  i_rd,
    output logic      [7:0]            o_rdata,
    // Pins
    input  wire logic                  i_dedicated_irq_pin,
    input  wire logic [LOW_PINS+HIGH_PINS-1:0] i_pin_change,
    // Core side
    input  wire logic                  i_global_ie,
    input  wire logic                  i_ack_dedicated,
    input  wire logic                  i_ack_upper,
    input  wire logic                  i_ack_lower,
    output logic                       o_dedicated_req,
    output logic                       o_upper_group_request,
    output logic                       o_lower_group_request,
    // Event interrupt and wake
    output logic                       o_irq,
    output logic                       o_wake
);

    localparam int NPC  = LOW_PINS + HIGH_PINS;
    localparam int NALL = NPC + 1;
    localparam int DED  = NPC;

    // Registers
    logic [7:0]      pin_change_mask_low_ff;
    logic [7:0]      pin_change_mask_high_ff;
    logic [1:0]      pin_sense_select_ff;
    logic [7:0]      interrupt_enable_mask_ff;
    logic [7:0]      interrupt_request_flags_ff;
    logic [7:0]      evt_status_ff;
    logic [7:0]      evt_mask_ff;
    logic [7:0]      rdata_ff;

    // Pin conditioning
    logic [NALL-1:0] sync1_ff;
    logic [NALL-1:0] sync2_ff;
    logic [NALL-1:0] sync3_ff;
    logic [NALL-1:0] filt_ff;
    logic [NALL-1:0] nxt_filt;
    logic [NALL-1:0] change;
    logic [1:0]      arm_cnt_ff;
    logic            armed;

    // Outputs
    logic            ded_req_ff;
    logic            upper_req_ff;
    logic            lower_req_ff;
    logic            irq_ff;
    logic            wake_ff;

    // Event decode
    ext_irq_pkg::sense_e sense;
    logic            level_mode;
    logic            ded_trig;
    logic            ded_low_onset;
    logic            upper_trig;
    logic            lower_trig;
    logic [7:0]      set_flags;
    logic [7:0]      clr_flags;
    logic [7:0]      nxt_flags;
    logic [7:0]      set_evt;
    logic [7:0]      nxt_evt;
    logic [NPC-1:0]  pc_enabled;
    logic            wake_async;
    logic [7:0]      nxt_rdata;

    function automatic logic [NALL-1:0] settle(
        input logic [NALL-1:0] s2,
        input logic [NALL-1:0] s3,
        input logic [NALL-1:0] prev
    );
        // Take a new level only once two later stages agree
        settle = (s2 & s3) | (prev & (s2 ^ s3));
    endfunction : settle

    function automatic logic hit(
        input logic [7:0] addr,
        input logic [7:0] ofs
    );
        hit = (addr == ofs);
    endfunction : hit

    assign o_rdata               = rdata_ff;
    assign o_dedicated_req       = ded_req_ff;
    assign o_upper_group_request = upper_req_ff;
    assign o_lower_group_request = lower_req_ff;
    assign o_irq                 = irq_ff;
    assign o_wake                = wake_ff;

    assign sense      = ext_irq_pkg::sense_e'(pin_sense_select_ff);
    assign level_mode = (sense == ext_irq_pkg::SENSE_LOW);
    assign armed      = (arm_cnt_ff == ext_irq_pkg::ARM_CYCLES);

    // Per-pin enable: mask bit and its group enable together
    assign pc_enabled = {
        pin_change_mask_high_ff[HIGH_PINS-1:0]
            & {HIGH_PINS{interrupt_enable_mask_ff[ext_irq_pkg::BIT_UPPER]}},
        pin_change_mask_low_ff[LOW_PINS-1:0]
            & {LOW_PINS{interrupt_enable_mask_ff[ext_irq_pkg::BIT_LOWER]}}
    };

    // Three-stage synchroniser; pin read even while driven out
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            sync3_ff <= '0;
        end else begin
            sync1_ff <= {i_dedicated_irq_pin, i_pin_change};
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end

    assign nxt_filt = settle(sync2_ff, sync3_ff, filt_ff);

    // Changes are ignored until the synchroniser chain has filled after reset,
    // but filt_ff is one stage behind, so an idle-high pin still fakes one edge.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            filt_ff    <= '0;
            arm_cnt_ff <= '0;
        end else begin
            filt_ff <= nxt_filt;
            if (!armed) begin
                arm_cnt_ff <= arm_cnt_ff + 2'h1;
            end
        end
    end

    assign change = (nxt_filt ^ filt_ff) & {NALL{armed}};

    // Dedicated pin trigger per sense selection; edges use the clock
    always_comb begin
        unique case (sense)
            ext_irq_pkg::SENSE_LOW:  ded_trig = 1'b0;
            ext_irq_pkg::SENSE_ANY:  ded_trig = change[DED];
            ext_irq_pkg::SENSE_FALL: ded_trig = change[DED] & ~nxt_filt[DED];
            ext_irq_pkg::SENSE_RISE: ded_trig = change[DED] & nxt_filt[DED];
        endcase
    end

    assign ded_low_onset = level_mode & change[DED] & ~nxt_filt[DED];
    assign upper_trig = |(change[NPC-1:LOW_PINS] & pc_enabled[NPC-1:LOW_PINS]);
    assign lower_trig = |(change[LOW_PINS-1:0] & pc_enabled[LOW_PINS-1:0]);

    always_comb begin
        set_flags = 8'h00;
        set_flags[ext_irq_pkg::BIT_DEDICATED] = ded_trig;
        set_flags[ext_irq_pkg::BIT_UPPER]     = upper_trig;
        set_flags[ext_irq_pkg::BIT_LOWER]     = lower_trig;
    end

    // Clear by writing one or by vectoring; zeros leave flags alone
    always_comb begin
        clr_flags = 8'h00;
        if (i_wr && hit(i_addr, ext_irq_pkg::OFS_FLAGS)) begin
            clr_flags = i_wdata & ext_irq_pkg::GROUP_BITS;
        end
        clr_flags[ext_irq_pkg::BIT_DEDICATED] =
            clr_flags[ext_irq_pkg::BIT_DEDICATED] | i_ack_dedicated;
        clr_flags[ext_irq_pkg::BIT_UPPER] =
            clr_flags[ext_irq_pkg::BIT_UPPER] | i_ack_upper;
        clr_flags[ext_irq_pkg::BIT_LOWER] =
            clr_flags[ext_irq_pkg::BIT_LOWER] | i_ack_lower;
    end

    // Set wins over a clear in the same cycle
    always_comb begin
        nxt_flags = (set_flags | (interrupt_request_flags_ff & ~clr_flags))
                    & ext_irq_pkg::GROUP_BITS;
        if (level_mode) begin
            nxt_flags[ext_irq_pkg::BIT_DEDICATED] = 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            interrupt_request_flags_ff <= ext_irq_pkg::RST_FLAGS;
        end else begin
            interrupt_request_flags_ff <= nxt_flags;
        end
    end

    // Software-written configuration
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pin_change_mask_low_ff   <= ext_irq_pkg::RST_MASK_LOW;
            pin_change_mask_high_ff  <= ext_irq_pkg::RST_MASK_HIGH;
            pin_sense_select_ff      <= ext_irq_pkg::RST_SENSE_CTRL[1:0];
            interrupt_enable_mask_ff <= ext_irq_pkg::RST_ENABLE;
            evt_mask_ff              <= ext_irq_pkg::RST_EVT_MASK;
        end else if (i_wr) begin
            if (hit(i_addr, ext_irq_pkg::OFS_MASK_LOW)) begin
                pin_change_mask_low_ff <= i_wdata;
            end
            if (hit(i_addr, ext_irq_pkg::OFS_MASK_HIGH)) begin
                pin_change_mask_high_ff <=
                    i_wdata & ext_irq_pkg::MASK_HIGH_BITS;
            end
            if (hit(i_addr, ext_irq_pkg::OFS_SENSE_CTRL)) begin
                pin_sense_select_ff <=
                    i_wdata[ext_irq_pkg::SENSE_LSB +: ext_irq_pkg::SENSE_W];
            end
            if (hit(i_addr, ext_irq_pkg::OFS_ENABLE)) begin
                interrupt_enable_mask_ff <=
                    i_wdata & ext_irq_pkg::GROUP_BITS;
            end
            if (hit(i_addr, ext_irq_pkg::OFS_EVT_MASK)) begin
                evt_mask_ff <= i_wdata & ext_irq_pkg::GROUP_BITS;
            end
        end
    end

    // Requests towards the core, gated by the global enable
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ded_req_ff   <= 1'b0;
            upper_req_ff <= 1'b0;
            lower_req_ff <= 1'b0;
        end else begin
            // Level request lasts only while the pin stays low
            ded_req_ff <= i_global_ie
                & interrupt_enable_mask_ff[ext_irq_pkg::BIT_DEDICATED]
                & (level_mode ? (armed & ~nxt_filt[DED])
                              : nxt_flags[ext_irq_pkg::BIT_DEDICATED]);
            upper_req_ff <= i_global_ie
                & interrupt_enable_mask_ff[ext_irq_pkg::BIT_UPPER]
                & nxt_flags[ext_irq_pkg::BIT_UPPER];
            lower_req_ff <= i_global_ie
                & interrupt_enable_mask_ff[ext_irq_pkg::BIT_LOWER]
                & nxt_flags[ext_irq_pkg::BIT_LOWER];
        end
    end

    // Sticky event status, cleared by reading it; set wins
    always_comb begin
        set_evt = 8'h00;
        set_evt[ext_irq_pkg::BIT_DEDICATED] = ded_trig | ded_low_onset;
        set_evt[ext_irq_pkg::BIT_UPPER]     = upper_trig;
        set_evt[ext_irq_pkg::BIT_LOWER]     = lower_trig;
        if (i_rd && hit(i_addr, ext_irq_pkg::OFS_EVT_STATUS)) begin
            nxt_evt = set_evt;
        end else begin
            nxt_evt = set_evt | evt_status_ff;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            evt_status_ff <= ext_irq_pkg::RST_EVT_STATUS;
            irq_ff        <= 1'b0;
        end else begin
            evt_status_ff <= nxt_evt;
            irq_ff        <= |(nxt_evt & evt_mask_ff);
        end
    end

    // Wake path works from the raw pins with no clock edge needed.
    // Pin-change inputs are compared against the settled level, so they stay quiet once the
    // clock has caught up; a low dedicated pin in level mode holds it up; glitches on the pins may wake spuriously.
    assign wake_async =
        (level_mode & interrupt_enable_mask_ff[ext_irq_pkg::BIT_DEDICATED]
            & ~i_dedicated_irq_pin)
        | (armed & |((i_pin_change ^ filt_ff[NPC-1:0]) & pc_enabled));

    always_ff @(posedge i_clk or posedge wake_async) begin
        if (wake_async) begin
            wake_ff <= 1'b1;
        end else begin
            wake_ff <= 1'b0;
        end
    end

    // Read data one cycle after the strobe; unmapped reads zero
    always_comb begin
        nxt_rdata = 8'h00;
        if (i_rd) begin
            unique case (i_addr)
                ext_irq_pkg::OFS_MASK_LOW:
                    nxt_rdata = pin_change_mask_low_ff;
                ext_irq_pkg::OFS_MASK_HIGH:
                    nxt_rdata = pin_change_mask_high_ff;
                ext_irq_pkg::OFS_SENSE_CTRL:
                    nxt_rdata = {6'h00, pin_sense_select_ff};
                ext_irq_pkg::OFS_ENABLE:
                    nxt_rdata = interrupt_enable_mask_ff;
                ext_irq_pkg::OFS_FLAGS: begin
                    nxt_rdata = interrupt_request_flags_ff;
                    // Edge-mode flag lingers one cycle after the switch
                    nxt_rdata[ext_irq_pkg::BIT_DEDICATED] =
                        interrupt_request_flags_ff[ext_irq_pkg::BIT_DEDICATED]
                        & ~level_mode;
                end
                ext_irq_pkg::OFS_EVT_STATUS: nxt_rdata = evt_status_ff;
                ext_irq_pkg::OFS_EVT_MASK:   nxt_rdata = evt_mask_ff;
                default:                     nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

endmodule : external_pin_interrupt_ctrl

`default_nettype wire

// file: verilog/ext_irq_pkg.sv
package ext_irq_pkg;

    // Register bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // Register offsets
    localparam logic [7:0] OFS_MASK_LOW   = 8'h12;
    localparam logic [7:0] OFS_MASK_HIGH  = 8'h20;
    localparam logic [7:0] OFS_SENSE_CTRL = 8'h30;
    localparam logic [7:0] OFS_ENABLE     = 8'h31;
    localparam logic [7:0] OFS_FLAGS      = 8'h32;
    localparam logic [7:0] OFS_EVT_STATUS = 8'h33;
    localparam logic [7:0] OFS_EVT_MASK   = 8'h34;

    // Field positions: group bits shared by enable, flag, status and event mask, then the sense field
    localparam int BIT_DEDICATED = 6;
    localparam int BIT_UPPER     = 5;
    localparam int BIT_LOWER     = 4;
    localparam int SENSE_LSB     = 0;
    localparam int SENSE_W       = 2;

    // Writable bit masks; everything else reads zero
    localparam logic [7:0] GROUP_BITS     = 8'h70;
    localparam logic [7:0] MASK_HIGH_BITS = 8'h0f;
    localparam logic [7:0] SENSE_BITS     = 8'h03;

    // Reset values
    localparam logic [7:0] RST_MASK_LOW   = 8'h00;
    localparam logic [7:0] RST_MASK_HIGH  = 8'h00;
    localparam logic [7:0] RST_SENSE_CTRL = 8'h00;
    localparam logic [7:0] RST_ENABLE     = 8'h00;
    localparam logic [7:0] RST_FLAGS      = 8'h00;
    localparam logic [7:0] RST_EVT_STATUS = 8'h00;
    localparam logic [7:0] RST_EVT_MASK   = 8'h00;

    // Input conditioning: cycles before pin changes count after reset
    localparam logic [1:0] ARM_CYCLES = 2'h3;

    // Dedicated pin trigger selection
    typedef enum logic [1:0] {
        SENSE_LOW  = 2'b00,
        SENSE_ANY  = 2'b01,
        SENSE_FALL = 2'b10,
        SENSE_RISE = 2'b11
    } sense_e;

endpackage : ext_irq_pkg

// file: testbench/ext_irq_properties.sv
`timescale 1ns/100ps
`default_nettype none

module ext_irq_properties (
    // Clock, reset and register port
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    input  wire logic [7:0] o_rdata,
    // Core side
    input  wire logic       i_global_ie,
    input  wire logic       o_dedicated_req,
    input  wire logic       o_upper_group_request,
    input  wire logic       o_lower_group_request,
    input  wire logic       o_irq
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    sequence wr_rd(logic [7:0] a);
        i_wr && i_addr == a ##1 i_rd && i_addr == a;
    endsequence

    a_ded_gate: assert property (
        o_dedicated_req |-> $past(i_global_ie))
        else $error("dedicated request without global enable");
    a_upper_gate: assert property (
        o_upper_group_request |-> $past(i_global_ie))
        else $error("upper request without global enable");
    a_lower_gate: assert property (
        o_lower_group_request |-> $past(i_global_ie))
        else $error("lower request without global enable");
    a_flag_rsvd: assert property (
        $past(i_rd) && ($past(i_addr) == ext_irq_pkg::OFS_FLAGS
            || $past(i_addr) == ext_irq_pkg::OFS_ENABLE)
        |-> (o_rdata & ~ext_irq_pkg::GROUP_BITS) == 8'h00)
        else $error("reserved enable or flag bit reads one");
    a_high_rsvd: assert property (
        $past(i_rd) && $past(i_addr) == ext_irq_pkg::OFS_MASK_HIGH
        |-> o_rdata[7:4] == 4'h0)
        else $error("reserved upper mask bit reads one");
    a_enable_back: assert property (
        wr_rd(ext_irq_pkg::OFS_ENABLE)
        |=> o_rdata == ($past(i_wdata, 2) & ext_irq_pkg::GROUP_BITS))
        else $error("enable readback wrong");
    a_mlow_back: assert property (
        wr_rd(ext_irq_pkg::OFS_MASK_LOW)
        |=> o_rdata == $past(i_wdata, 2))
        else $error("lower mask readback wrong");
    a_mhigh_back: assert property (
        wr_rd(ext_irq_pkg::OFS_MASK_HIGH)
        |=> o_rdata == ($past(i_wdata, 2) & ext_irq_pkg::MASK_HIGH_BITS))
        else $error("upper mask readback wrong");
    a_sense_back: assert property (
        wr_rd(ext_irq_pkg::OFS_SENSE_CTRL)
        |=> o_rdata == ($past(i_wdata, 2) & ext_irq_pkg::SENSE_BITS))
        else $error("sense readback wrong");
    a_level_flag: assert property (
        i_wr && i_addr == ext_irq_pkg::OFS_SENSE_CTRL
            && i_wdata[1:0] == 2'b00
        ##1 i_rd && i_addr == ext_irq_pkg::OFS_FLAGS
        |=> !o_rdata[ext_irq_pkg::BIT_DEDICATED])
        else $error("dedicated flag set in level mode");

    c_ded: cover property (o_dedicated_req);
    c_lower_irq: cover property (o_lower_group_request && o_irq);
    c_upper: cover property (o_upper_group_request);
endmodule : ext_irq_properties

bind external_pin_interrupt_ctrl ext_irq_properties u_props (
    .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_global_ie(i_global_ie),
    .o_dedicated_req(o_dedicated_req), .o_irq(o_irq),
    .o_upper_group_request(o_upper_group_request),
    .o_lower_group_request(o_lower_group_request));

`default_nettype wire

// file: testbench/core_irq_model.sv
`timescale 1ns/100ps
`default_nettype none

module core_irq_model #(
    parameter int ACK_DELAY = 3
) (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    // Requests in, vectoring out
    input  wire logic       i_ack_en,
    input  wire logic [2:0] i_req,
    output logic      [2:0] o_ack
);
    logic [3:0] wait_ff [3];

    // Vector only after the request stood a while, like a busy core
    always_ff @(posedge i_clk) begin
        for (int i = 0; i < 3; i++) begin
            if (i_rst || !i_req[i] || o_ack[i]) begin
                wait_ff[i] <= 4'h0;
            end else begin
                wait_ff[i] <= wait_ff[i] + 4'h1;
            end
            o_ack[i] <= !i_rst && i_ack_en && i_req[i]
                        && wait_ff[i] == 4'(ACK_DELAY);
        end
    end
endmodule : core_irq_model

`default_nettype wire

// file: testbench/external_pin_interrupt_ctrl_tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module external_pin_interrupt_ctrl_tb_top;
    typedef struct packed {
        logic [1:0] sense;
        logic       pre;
        logic       post;
        logic [7:0] exp;
    } row_s;

    logic        i_clk, i_rst, i_wr, i_rd, pin, i_global_ie, ack_en;
    logic [7:0]  i_addr, i_wdata, o_rdata;
    logic [11:0] i_pin_change;
    logic [2:0]  ack;
    logic        ded_req, up_req, low_req, o_irq, o_wake;
    int          error_cnt, tests_run, cycle_cnt;
    row_s        rows [7] = '{'{2'h1, 1'b1, 1'b0, 8'h40},
        '{2'h1, 1'b0, 1'b1, 8'h40}, '{2'h2, 1'b1, 1'b0, 8'h40},
        '{2'h2, 1'b0, 1'b1, 8'h00}, '{2'h3, 1'b0, 1'b1, 8'h40},
        '{2'h3, 1'b1, 1'b0, 8'h00}, '{2'h0, 1'b1, 1'b0, 8'h00}};
    logic [7:0]  ofs [7] = '{8'h12, 8'h20, 8'h30, 8'h31, 8'h32, 8'h33, 8'h34};

    external_pin_interrupt_ctrl DUT (
        .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_dedicated_irq_pin(pin), .i_pin_change(i_pin_change),
        .i_global_ie(i_global_ie), .i_ack_dedicated(ack[2]),
        .i_ack_upper(ack[1]), .i_ack_lower(ack[0]),
        .o_dedicated_req(ded_req), .o_upper_group_request(up_req),
        .o_lower_group_request(low_req), .o_irq(o_irq), .o_wake(o_wake));

    core_irq_model #(.ACK_DELAY(3)) u_core (.i_clk(i_clk), .i_rst(i_rst),
        .i_ack_en(ack_en), .i_req({ded_req, up_req, low_req}), .o_ack(ack));

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    task finish_test;
        if (error_cnt == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finish_test

    // Cap well above the few hundred cycles the sequence needs
    always @(posedge i_clk) begin
        cycle_cnt <= cycle_cnt + 1;
        if (cycle_cnt == 6000) begin
            error_cnt++;
            finish_test();
        end
    end

    task check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check

    // Bus tasks start and end right on a rising edge. A write leaves
    // its strobe up and the next task lowers it, so back-to-back
    // writes never assign the strobe twice in one time step.
    task wr(input logic [7:0] a, input logic [7:0] d);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
    endtask : wr

    task rd(input logic [7:0] a, input logic [7:0] e);
        i_wr <= 1'b0;
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(negedge i_clk);
        check(o_rdata, e);
        @(posedge i_clk);
    endtask : rd

    task wait_n(input int n);
        i_wr <= 1'b0;
        repeat (n) @(posedge i_clk);
    endtask : wait_n

    // Order: dedicated, upper, lower, irq, wake
    task outs(input logic [4:0] e);
        @(negedge i_clk);
        check({3'h0, ded_req, up_req, low_req, o_irq, o_wake}, {3'h0, e});
        @(posedge i_clk);
    endtask : outs

    initial begin
        {i_rst, i_wr, i_rd, pin, i_global_ie, ack_en} = 6'b100000;
        {i_addr, i_wdata, i_pin_change} = 28'h0;
        {error_cnt, tests_run} = 0;
        repeat (5) @(posedge i_clk);
        i_rst <= 1'b0;
        wait_n(4);
        foreach (rows[i]) begin
            wr(8'h30, {6'h0, rows[i].sense});
            pin <= rows[i].pre;
            wait_n(6);
            wr(8'h32, 8'h70);
            pin <= rows[i].post;
            wait_n(6);
            rd(8'h32, rows[i].exp);
        end
        // Second reset in mid-run
        i_rst <= 1'b1;
        wait_n(2);
        i_rst <= 1'b0;
        wait_n(4);
        foreach (ofs[i]) rd(ofs[i], 8'h00);
        wr(8'h20, 8'hff);
        rd(8'h20, 8'h0f);
        wr(8'h31, 8'hff);
        rd(8'h31, 8'h70);
        wr(8'h30, 8'hff);
        rd(8'h30, 8'h03);
        wr(8'h12, 8'ha5);
        rd(8'h12, 8'ha5);
        rd(8'h55, 8'h00);
        wr(8'h32, 8'hff);
        rd(8'h32, 8'h00);
        wr(8'h30, 8'h02);
        wr(8'h31, 8'h40);
        pin <= 1'b1;
        wait_n(6);
        wr(8'h32, 8'h70);
        pin <= 1'b0;
        wait_n(6);
        outs(5'h00);
        rd(8'h32, 8'h40);
        wr(8'h32, 8'h00);
        rd(8'h32, 8'h40);
        i_global_ie <= 1'b1;
        wait_n(2);
        outs(5'h10);
        ack_en <= 1'b1;
        wait_n(8);
        outs(5'h00);
        ack_en <= 1'b0;
        rd(8'h32, 8'h00);
        // Two-cycle pulse must be caught
        pin <= 1'b1;
        wait_n(6);
        wr(8'h32, 8'h70);
        pin <= 1'b0;
        wait_n(2);
        pin <= 1'b1;
        wait_n(6);
        wr(8'h31, 8'h40);
        rd(8'h32, 8'h40);
        wr(8'h32, 8'h40);
        rd(8'h32, 8'h00);
        wr(8'h30, 8'h00);
        rd(8'h32, 8'h00);
        // Driver holds the level until the global enable is dropped
        pin <= 1'b0;
        wait_n(6);
        outs(5'h11);
        i_global_ie <= 1'b0;
        wait_n(2);
        outs(5'h01);
        pin <= 1'b1;
        wr(8'h31, 8'h30);
        wr(8'h12, 8'h04);
        wr(8'h20, 8'h02);
        wr(8'h34, 8'h10);
        wr(8'h32, 8'h70);
        i_wr <= 1'b0;
        i_rd <= 1'b1;
        i_addr <= 8'h33;
        @(posedge i_clk);
        i_rd <= 1'b0;
        i_global_ie <= 1'b1;
        i_pin_change <= 12'h008;
        wait_n(6);
        rd(8'h32, 8'h00);
        i_pin_change <= 12'h00c;
        wait_n(6);
        rd(8'h32, 8'h10);
        outs(5'h06);
        rd(8'h33, 8'h10);
        rd(8'h33, 8'h00);
        outs(5'h04);
        i_pin_change <= 12'h20c;
        wait_n(6);
        rd(8'h32, 8'h30);
        outs(5'h0c);
        wr(8'h31, 8'h10);
        wr(8'h32, 8'h20);
        i_pin_change <= 12'h00c;
        wait_n(6);
        rd(8'h32, 8'h10);
        outs(5'h04);
        finish_test();
    end
endmodule : external_pin_interrupt_ctrl_tb_top

`default_nettype wire
